// ===== fir_regs.svh
// Purpose: Constants of the flash identity readout: opcodes, phase lengths and table bytes.
// Assumes: Included by its bare name from the package and the readout module.
// Notes:   Definitions only.
`ifndef FIR_REGS_SVH
`define FIR_REGS_SVH

// Instruction opcodes.
`define FIR_OPC_UNIQUE_ID     8'h4B
`define FIR_OPC_IDENTITY      8'h9F
`define FIR_OPC_DISCOVERY     8'h5A

// Last value of the link clock counter in each phase.
`define FIR_OPC_LAST          6'h07
`define FIR_ADDR_LAST         6'h17
`define FIR_UID_DUMMY_LAST    6'h1F
`define FIR_DISC_DUMMY_LAST   6'h07

// Last byte index before a readout wraps.
`define FIR_IDENT_LAST        8'h02
`define FIR_UID_LAST          8'h07

// Discoverable-parameter space offsets.
`define FIR_OFS_SIG0          8'h00
`define FIR_OFS_SIG1          8'h01
`define FIR_OFS_SIG2          8'h02
`define FIR_OFS_SIG3          8'h03
`define FIR_OFS_MINOR_REV     8'h04
`define FIR_OFS_MAJOR_REV     8'h05
`define FIR_OFS_HDR_COUNT     8'h06
`define FIR_OFS_HDR0_MAKER    8'h08
`define FIR_OFS_HDR0_MINOR    8'h09
`define FIR_OFS_HDR0_MAJOR    8'h0A
`define FIR_OFS_HDR0_LENGTH   8'h0B
`define FIR_OFS_HDR0_PTR_LO   8'h0C
`define FIR_OFS_HDR0_PTR_MID  8'h0D
`define FIR_OFS_HDR0_PTR_HI   8'h0E

// Discoverable-parameter space values.
`define FIR_VAL_SIG0          8'h53
`define FIR_VAL_SIG1          8'h46
`define FIR_VAL_SIG2          8'h44
`define FIR_VAL_SIG3          8'h50
`define FIR_VAL_MINOR_REV     8'h01
`define FIR_VAL_MAJOR_REV     8'h01
`define FIR_VAL_HDR_COUNT     8'h00
`define FIR_VAL_HDR0_MINOR    8'h00
`define FIR_VAL_HDR0_MAJOR    8'h01
`define FIR_VAL_HDR0_LENGTH   8'h04
`define FIR_VAL_HDR0_PTR_LO   8'h80
`define FIR_VAL_HDR0_PTR_MID  8'h00
`define FIR_VAL_HDR0_PTR_HI   8'h00
`define FIR_VAL_RESERVED      8'hFF

`endif

// ===== fir_pkg.sv
// Purpose: Types shared by the flash identity readout.
// Assumes: Constants come from fir_regs.svh.
// Notes:   Types only.
`default_nettype none
`include "fir_regs.svh"

package fir_pkg;

  typedef enum logic [2:0] {
    ph_opcode,
    ph_addr,
    ph_dummy,
    ph_data,
    ph_idle
  } fir_phase_t;

  typedef enum logic [1:0] {
    src_none,
    src_uid,
    src_ident,
    src_disc
  } fir_src_t;

  typedef struct packed {
    fir_phase_t  phase;
    fir_src_t    src;
    logic [5:0]  cnt;
    logic [7:0]  opc;
    logic [7:0]  addr;
    logic [7:0]  byte_idx;
    logic [2:0]  bit_idx;
    logic        cmd_seen;
  } fir_rise_t;

  typedef struct packed {
    logic        dout;
    logic        doe;
  } fir_fall_t;

  typedef struct packed {
    logic        cmd_seen_d;
    logic        busy;
    logic [7:0]  last_cmd;
    logic [15:0] cmd_count;
    logic        unknown_cmd;
  } fir_core_t;

endpackage

`default_nettype wire

// ===== fir_sync.sv
// Purpose: Two-stage synchroniser for a group of levels.
// Assumes: Inputs are levels that stay put for several destination clocks.
// Notes:   The first stage feeds only the second stage.
`default_nettype none

module fir_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } fir_sync_state_t;

  fir_sync_state_t st_q;
  fir_sync_state_t st_d;

  always_comb
  begin
    st_d.meta   = async_in;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stable;

endmodule // fir_sync

`default_nettype wire

// ===== fir_readout.sv
// Purpose: Identification readout of a serial flash over its serial peripheral link.
// Assumes: Link logic runs on spi_clk_in, mode 0: input sampled on rising, output on falling.
// Notes:   Chip select high clears the whole link side, so each frame starts fresh.
//
// Operation
// RQ1: After opcode 4Bh and thirty-two dummy clocks the 64-bit unique number is shifted out.
// RQ2: The unique number is a fixed per-part value with no path that can change it.
// RQ3: After opcode 9Fh the maker, memory type and capacity bytes go out MSB first on falls.
// RQ4: The host opens a discovery read with chip select low, opcode 5Ah and a 24-bit address.
// RQ5: Eight dummy clocks follow the address and data starts on the fall of the 40th clock.
// RQ6: Only the low eight address bits are used as the starting offset in the 256-byte space.
// RQ7: Offsets 04h and 05h report revision 1.1 as 01h and 01h.
// RQ8: Offset 06h holds 00h, meaning one parameter header follows.
// RQ9: The header at 08h starts with the maker byte and reports revision 1.0 at 09h and 0Ah.
// RQ10: Offset 0Bh gives the basic table length as 04h double words.
// RQ11: Offsets 0Ch to 0Eh hold the table pointer 000080h, least significant byte first.
// RQ12: Discovery bytes keep coming from rising offsets until chip select goes high.
`default_nettype none
`include "fir_regs.svh"

module fir_readout #(
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF,  // Arbitrary value, set per part.
  parameter logic [7:0]  MAKER_ID  = 8'hA5,                    // Arbitrary value.
  parameter logic [7:0]  MEM_TYPE  = 8'h40,                    // Arbitrary value.
  parameter logic [7:0]  CAPACITY  = 8'h13                     // Arbitrary value.
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        spi_clk_in,
  input  wire logic        cs_n_in,
  input  wire logic        serial_in_pin_in,
  output logic             serial_out_pin_out,
  output logic             serial_out_oe_out,
  output logic             busy_out,
  output logic [7:0]       last_cmd_out,
  output logic [15:0]      cmd_count_out,
  output logic             unknown_cmd_out
);

  // Reset release on the reference clock.
  logic                rst_n_sync;

  // Link side state, one struct per clock edge.
  fir_pkg::fir_rise_t  rise_q;
  fir_pkg::fir_rise_t  rise_d;
  fir_pkg::fir_fall_t  fall_q;
  fir_pkg::fir_fall_t  fall_d;

  // Reference side state.
  fir_pkg::fir_core_t  core_q;
  fir_pkg::fir_core_t  core_d;

  // Levels carried into the reference domain.
  logic [1:0]          link_sync;
  logic                cs_n_sync;
  logic                cmd_seen_sync;

  // Byte that the falling edge shifts from.
  logic [7:0]          cur_byte;

  // Decoded views of the link state.
  logic                dummy_done;
  logic                known_opc;

  fir_sync #(
    .WIDTH (1)
  ) u_rst_sync (
    .clk_in   (ref_clk_in),
    .rst_n_in (rstn_in),
    .async_in (1'b1),
    .sync_out (rst_n_sync)
  );

  // Byte table of the three readouts.
  function automatic logic [7:0] fir_byte_at(
    input fir_pkg::fir_src_t src,
    input logic [7:0]        idx
  );
    logic [7:0] val;
    val = `FIR_VAL_RESERVED;
    unique case (src)
      fir_pkg::src_uid:
      begin
        // Byte 0 is the most significant, so the number reads out MSB first.
        unique case (idx[2:0])  // RQ2
          3'h0: val = UNIQUE_ID[63:56];  // RQ1
          3'h1: val = UNIQUE_ID[55:48];
          3'h2: val = UNIQUE_ID[47:40];
          3'h3: val = UNIQUE_ID[39:32];
          3'h4: val = UNIQUE_ID[31:24];
          3'h5: val = UNIQUE_ID[23:16];
          3'h6: val = UNIQUE_ID[15:8];
          3'h7: val = UNIQUE_ID[7:0];
        endcase
      end
      fir_pkg::src_ident:
      begin
        unique case (idx)
          8'h00:   val = MAKER_ID;  // RQ3
          8'h01:   val = MEM_TYPE;  // RQ3
          8'h02:   val = CAPACITY;  // RQ3
          default: val = `FIR_VAL_RESERVED;
        endcase
      end
      fir_pkg::src_disc:
      begin
        unique case (idx)
          `FIR_OFS_SIG0:         val = `FIR_VAL_SIG0;
          `FIR_OFS_SIG1:         val = `FIR_VAL_SIG1;
          `FIR_OFS_SIG2:         val = `FIR_VAL_SIG2;
          `FIR_OFS_SIG3:         val = `FIR_VAL_SIG3;
          `FIR_OFS_MINOR_REV:    val = `FIR_VAL_MINOR_REV;  // RQ7
          `FIR_OFS_MAJOR_REV:    val = `FIR_VAL_MAJOR_REV;  // RQ7
          `FIR_OFS_HDR_COUNT:    val = `FIR_VAL_HDR_COUNT;  // RQ8
          `FIR_OFS_HDR0_MAKER:   val = MAKER_ID;  // RQ9
          `FIR_OFS_HDR0_MINOR:   val = `FIR_VAL_HDR0_MINOR;  // RQ9
          `FIR_OFS_HDR0_MAJOR:   val = `FIR_VAL_HDR0_MAJOR;  // RQ9
          `FIR_OFS_HDR0_LENGTH:  val = `FIR_VAL_HDR0_LENGTH;  // RQ10
          `FIR_OFS_HDR0_PTR_LO:  val = `FIR_VAL_HDR0_PTR_LO;  // RQ11
          `FIR_OFS_HDR0_PTR_MID: val = `FIR_VAL_HDR0_PTR_MID;  // RQ11
          `FIR_OFS_HDR0_PTR_HI:  val = `FIR_VAL_HDR0_PTR_HI;  // RQ11
          default:               val = `FIR_VAL_RESERVED;
        endcase
      end
      default:
      begin
        val = `FIR_VAL_RESERVED;
      end
    endcase
    return val;
  endfunction

  // The dummy length depends on the instruction; other sources never reach this phase.
  always_comb
  begin
    unique case (rise_q.src)
      fir_pkg::src_uid:   dummy_done = (rise_q.cnt == `FIR_UID_DUMMY_LAST);   // RQ1
      fir_pkg::src_disc:  dummy_done = (rise_q.cnt == `FIR_DISC_DUMMY_LAST);  // RQ5
      fir_pkg::src_ident: dummy_done = 1'b0;
      fir_pkg::src_none:  dummy_done = 1'b0;
    endcase
  end

  // Rising edge: opcode, address and dummy counting, and the readout position.
  always_comb
  begin
    rise_d = rise_q;
    unique case (rise_q.phase)
      fir_pkg::ph_opcode:
      begin
        rise_d.opc = {rise_q.opc[6:0], serial_in_pin_in};
        rise_d.cnt = rise_q.cnt + 6'h01;
        if (rise_q.cnt == `FIR_OPC_LAST)
        begin
          rise_d.cmd_seen = 1'b1;
          rise_d.cnt      = 6'h00;
          unique case ({rise_q.opc[6:0], serial_in_pin_in})
            `FIR_OPC_UNIQUE_ID:
            begin
              rise_d.phase = fir_pkg::ph_dummy;  // RQ1
              rise_d.src   = fir_pkg::src_uid;
            end
            `FIR_OPC_IDENTITY:
            begin
              rise_d.phase    = fir_pkg::ph_data;  // RQ3
              rise_d.src      = fir_pkg::src_ident;
              rise_d.byte_idx = 8'h00;
              rise_d.bit_idx  = 3'h7;
            end
            `FIR_OPC_DISCOVERY:
            begin
              rise_d.phase = fir_pkg::ph_addr;  // RQ4
              rise_d.src   = fir_pkg::src_disc;
            end
            default:
            begin
              rise_d.phase = fir_pkg::ph_idle;
            end
          endcase
        end
      end
      fir_pkg::ph_addr:
      begin
        // The upper address bits simply fall off the end of this register.
        rise_d.addr = {rise_q.addr[6:0], serial_in_pin_in};  // RQ6
        rise_d.cnt  = rise_q.cnt + 6'h01;
        if (rise_q.cnt == `FIR_ADDR_LAST)
        begin
          rise_d.phase = fir_pkg::ph_dummy;
          rise_d.cnt   = 6'h00;
        end
      end
      fir_pkg::ph_dummy:
      begin
        rise_d.cnt = rise_q.cnt + 6'h01;
        if (dummy_done)
        begin
          rise_d.phase    = fir_pkg::ph_data;
          rise_d.cnt      = 6'h00;
          rise_d.bit_idx  = 3'h7;
          rise_d.byte_idx = (rise_q.src == fir_pkg::src_disc) ? rise_q.addr : 8'h00;  // RQ6
        end
      end
      fir_pkg::ph_data:
      begin
        rise_d.bit_idx = rise_q.bit_idx - 3'h1;
        if (rise_q.bit_idx == 3'h0)
        begin
          unique case (rise_q.src)
            fir_pkg::src_uid:
            begin
              rise_d.byte_idx = (rise_q.byte_idx == `FIR_UID_LAST) ? 8'h00
                              : rise_q.byte_idx + 8'h01;
            end
            fir_pkg::src_ident:
            begin
              rise_d.byte_idx = (rise_q.byte_idx == `FIR_IDENT_LAST) ? 8'h00
                              : rise_q.byte_idx + 8'h01;
            end
            fir_pkg::src_disc:
            begin
              // Eight bits wrap at the top of the 256-byte space.
              rise_d.byte_idx = rise_q.byte_idx + 8'h01;  // RQ12
            end
            fir_pkg::src_none:
            begin
              rise_d.byte_idx = rise_q.byte_idx;
            end
          endcase
        end
      end
      fir_pkg::ph_idle:
      begin
        // A refused opcode leaves the rest of the frame unheard until chip select rises.
        rise_d = rise_q;
      end
      default:
      begin
        rise_d = rise_q;
      end
    endcase
  end

  // A frame is ended by chip select itself, since the link clock stops between frames.
  always_ff @(posedge spi_clk_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      rise_q <= '0;  // RQ12
    end
    else
    begin
      rise_q <= rise_d;
    end
  end

  assign cur_byte = fir_byte_at(rise_q.src, rise_q.byte_idx);

  // Falling edge: drive the bit chosen at the rising edge before, MSB first.
  always_comb
  begin
    fall_d.doe  = 1'b0;
    fall_d.dout = 1'b0;
    if (rise_q.phase == fir_pkg::ph_data)
    begin
      fall_d.doe  = 1'b1;  // RQ5
      fall_d.dout = cur_byte[rise_q.bit_idx];  // RQ3
    end
  end

  always_ff @(negedge spi_clk_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      fall_q <= '0;
    end
    else
    begin
      fall_q <= fall_d;
    end
  end

  assign serial_out_pin_out = fall_q.dout;
  assign serial_out_oe_out  = fall_q.doe;

  // Chip select and the opcode-seen level cross as levels.
  fir_sync #(
    .WIDTH (2)
  ) u_link_sync (
    .clk_in   (ref_clk_in),
    .rst_n_in (rst_n_sync),
    .async_in ({~cs_n_in, rise_q.cmd_seen}),
    .sync_out (link_sync)
  );

  // Chip select crosses inverted, so the synchroniser's zero reset reads as deselected
  // and busy does not pulse when reset lets go.
  assign cs_n_sync     = ~link_sync[1];
  assign cmd_seen_sync = link_sync[0];

  // Opcodes with a readout behind them; anything else is refused.
  always_comb
  begin
    unique case (rise_q.opc)
      `FIR_OPC_UNIQUE_ID: known_opc = 1'b1;
      `FIR_OPC_IDENTITY:  known_opc = 1'b1;
      `FIR_OPC_DISCOVERY: known_opc = 1'b1;
      default:            known_opc = 1'b0;
    endcase
  end

  // The opcode is frozen while the seen level is high, so reading it on the level's
  // arrival is safe. A frame that ends within two reference clocks of its opcode may
  // be missed or read back as zero.
  always_comb
  begin
    core_d            = core_q;
    core_d.busy       = ~cs_n_sync;
    core_d.cmd_seen_d = cmd_seen_sync;
    if (cmd_seen_sync && !core_q.cmd_seen_d)
    begin
      core_d.last_cmd    = rise_q.opc;
      core_d.cmd_count   = core_q.cmd_count + 16'h0001;
      core_d.unknown_cmd = ~known_opc;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      core_q <= '0;
    end
    else
    begin
      core_q <= core_d;
    end
  end

  assign busy_out        = core_q.busy;
  assign last_cmd_out    = core_q.last_cmd;
  assign cmd_count_out   = core_q.cmd_count;
  assign unknown_cmd_out = core_q.unknown_cmd;

endmodule // fir_readout

`default_nettype wire

// ===== fir_readout_asserts.sv
// Purpose: Port checks of the flash identity readout.
// Assumes: Bound to fir_readout; chip select clears the link helpers.
// Notes:   Link checks sample on rises, where the falling-edge data has settled; a_fall_only samples on falls.
`default_nettype none
module fir_readout_chk (
  input wire logic        ref_clk_in,
  input wire logic        rstn_in,
  input wire logic        spi_clk_in,
  input wire logic        cs_n_in,
  input wire logic        serial_in_pin_in,
  input wire logic        serial_out_pin_out,
  input wire logic        serial_out_oe_out,
  input wire logic        busy_out,
  input wire logic [7:0]  last_cmd_out,
  input wire logic [15:0] cmd_count_out,
  input wire logic        unknown_cmd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cnt_q;
  logic [7:0] opc_q;
  logic       pin_rise_q;
  always_ff @(posedge spi_clk_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      cnt_q <= 6'h00;
      opc_q <= 8'h00;
      pin_rise_q <= 1'b0;
    end
    else
    begin
      cnt_q <= (cnt_q == 6'h3F) ? cnt_q : cnt_q + 6'h01;
      opc_q <= (cnt_q < 6'h08) ? {opc_q[6:0], serial_in_pin_in} : opc_q;
      pin_rise_q <= serial_out_pin_out;
    end
  end
  sequence s_cs_quiet;
    cs_n_in [*5];
  endsequence
  sequence s_long_op;
    opc_q == 8'h4B || opc_q == 8'h5A;
  endsequence
  a_ident_start: assert property (@(posedge spi_clk_in) disable iff (cs_n_in)
    cnt_q == 6'h08 && opc_q == 8'h9F |-> serial_out_oe_out) else $error("identity late");
  a_long_wait: assert property (@(posedge spi_clk_in) disable iff (cs_n_in)
    s_long_op ##0 cnt_q == 6'h27 |-> !serial_out_oe_out) else $error("data too early");
  a_long_start: assert property (@(posedge spi_clk_in) disable iff (cs_n_in)
    s_long_op ##0 cnt_q == 6'h28 |-> serial_out_oe_out) else $error("data not started");
  a_refuse_quiet: assert property (@(posedge spi_clk_in) disable iff (cs_n_in)
    cnt_q >= 6'h08 && !(opc_q inside {8'h4B, 8'h9F, 8'h5A}) |-> !serial_out_oe_out)
    else $error("drive on unknown opcode");
  a_oe_idle: assert property (@(posedge ref_clk_in)
    cs_n_in |-> !serial_out_oe_out) else $error("drive while deselected");
  a_out_zero: assert property (@(posedge ref_clk_in)
    !serial_out_oe_out |-> !serial_out_pin_out) else $error("data while not driving");
  a_fall_only: assert property (@(negedge spi_clk_in) disable iff (cs_n_in)
    serial_out_pin_out == pin_rise_q) else $error("data moved while clock high");
  a_busy_rise: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    $fell(cs_n_in) |-> ##[2:4] busy_out) else $error("busy late");
  a_busy_quiet: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    s_cs_quiet |-> !busy_out) else $error("busy while idle");
  a_count_step: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    $changed(cmd_count_out) |-> cmd_count_out == $past(cmd_count_out) + 16'h0001)
    else $error("count jumped");
  a_unknown_flag: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    $changed(cmd_count_out) |=> unknown_cmd_out == !(last_cmd_out inside
    {8'h4B, 8'h9F, 8'h5A})) else $error("unknown flag wrong");
endmodule // fir_readout_chk
bind fir_readout fir_readout_chk chk (.ref_clk_in, .rstn_in, .spi_clk_in, .cs_n_in,
  .serial_in_pin_in, .serial_out_pin_out, .serial_out_oe_out, .busy_out, .last_cmd_out,
  .cmd_count_out, .unknown_cmd_out);
`default_nettype wire

// ===== fir_host_model.sv
// Purpose: Host link controller, mode 0, with a 32 ns link clock.
// Assumes: Frames are started by the bench through xfer.
// Notes:   Idle input bits toggle so a stale level cannot pass unnoticed.
`default_nettype none
module fir_host_model (
  input  wire logic       data_in,
  output var  logic       spi_clk_out,
  output var  logic       cs_n_out,
  output var  logic       data_out,
  output var  logic [7:0] rx_byte_out,
  output var  logic       rx_stb_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  initial
  begin
    spi_clk_out = 1'b0;
    cs_n_out    = 1'b1;
    data_out    = 1'b0;
    rx_byte_out = 8'h00;
    rx_stb_out  = 1'b0;
  end
  task automatic tick(input logic b);
    data_out = b;
    #16 spi_clk_out = 1'b1;
    sh = {sh[6:0], data_in};
    #16 spi_clk_out = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] opc, input logic [23:0] a, input int nab,
                      input int ndum, input int nbyt);
    int i;
    cs_n_out = 1'b0;
    #16;
    for (i = 7; i >= 0; i--) tick(opc[i]);
    for (i = 8 * nab - 1; i >= 0; i--) tick(a[i]);
    for (i = 0; i < 8 * (ndum + nbyt); i++)
    begin
      tick(~data_out);
      if (i >= 8 * ndum && i % 8 == 7)
      begin
        rx_byte_out = sh;
        rx_stb_out = 1'b1;
        #1 rx_stb_out = 1'b0;
      end
    end
    #16 cs_n_out = 1'b1;
    data_out = ~data_out;
  endtask
endmodule // fir_host_model
`default_nettype wire

// ===== tb_flash_identity_readout.sv
// Purpose: Self-checking bench of the flash identity readout.
// Assumes: Host model drives the link; bytes are compared from a queue.
// Notes:   Status outputs are checked a few reference clocks after each frame.
`default_nettype none
module tb_flash_identity_readout;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] UID = 64'h0123_4567_89AB_CDEF;
  logic        ref_clk_in, rstn_in, spi_clk_in, cs_n_in, serial_in_pin_in;
  logic        serial_out_pin_out, serial_out_oe_out, busy_out, unknown_cmd_out;
  logic [7:0]  last_cmd_out, rx_byte_out;
  logic [15:0] cmd_count_out;
  logic        rx_stb_out;
  logic [7:0]  expq [$];
  int          err_count, samples_checked, nframes;
  fir_readout #(.UNIQUE_ID(UID)) uut (.ref_clk_in, .rstn_in, .spi_clk_in, .cs_n_in,
    .serial_in_pin_in, .serial_out_pin_out, .serial_out_oe_out, .busy_out,
    .last_cmd_out, .cmd_count_out, .unknown_cmd_out);
  fir_host_model host (.data_in(serial_out_pin_out), .spi_clk_out(spi_clk_in),
    .cs_n_out(cs_n_in), .data_out(serial_in_pin_in), .rx_byte_out, .rx_stb_out);
  initial
  begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] exp_byte(input logic [7:0] opc, input logic [7:0] i);
    int j = i % 8;
    logic [7:0] t [16] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h01, 8'h01, 8'h00, 8'hFF,
                           8'hA5, 8'h00, 8'h01, 8'h04, 8'h80, 8'h00, 8'h00, 8'hFF};
    if (opc == 8'h9F) return (i % 3 == 0) ? 8'hA5 : (i % 3 == 1) ? 8'h40 : 8'h13;
    if (opc == 8'h4B) return UID[8 * (7 - j) +: 8];
    if (opc == 8'h5A) return (i < 8'h10) ? t[i[3:0]] : 8'hFF;
    return 8'h00;
  endfunction
  task automatic run(input logic [7:0] opc, input logic [7:0] a, input int nbyt);
    int k;
    for (k = 0; k < nbyt; k++) expq.push_back(exp_byte(opc, a + k[7:0]));
    if (opc == 8'h5A) host.xfer(opc, {16'h0000, a}, 3, 1, nbyt);
    else host.xfer(opc, 24'h000000, 0, (opc == 8'h4B) ? 4 : 0, nbyt);
    nframes++;
    repeat (10) @(negedge ref_clk_in);
    check({8'h00, last_cmd_out}, {8'h00, opc});
    check(cmd_count_out, nframes[15:0]);
    check({15'h0000, unknown_cmd_out}, {15'h0000, !(opc inside {8'h4B, 8'h9F, 8'h5A})});
    check({14'h0000, busy_out, serial_out_oe_out}, 16'h0000);
  endtask
  always @(posedge rx_stb_out)
  begin
    check({8'h00, rx_byte_out}, {8'h00, expq.pop_front()});
  end
  task automatic wrap_up();
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #500us;
    err_count++;
    wrap_up();
  end
  initial
  begin
    rstn_in = 1'b0;
    void'($urandom(97717));
    repeat (10) @(posedge ref_clk_in);
    @(negedge ref_clk_in) rstn_in = 1'b1;
    repeat (5) @(negedge ref_clk_in);
    run(8'h9F, 8'h00, 4);
    run(8'h4B, 8'h00, 9);
    run(8'h4B, 8'h00, 8);
    run(8'h5A, 8'h00, 16);
    run(8'h5A, 8'hFE, 3);
    run(8'h03, 8'h00, 2);
    repeat (4) run(8'h5A, 8'($urandom), 1 + int'($urandom % 4));
    check(16'(expq.size()), 16'h0000);
    wrap_up();
  end
endmodule // tb_flash_identity_readout
`default_nettype wire
